/* File: hdl/pfm_defs.svh */
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH

`define PFM_ADDR_SEL0   32'hE002C000
`define PFM_ADDR_SEL1   32'hE002C004
`define PFM_ADDR_SEL2   32'hE002C014
`define PFM_ADDR_WORD   14:2
`define PFM_RESET_SEL   32'h00000000
`define PFM_NPINS       5
`define PFM_FIELD_W     2
`define PFM_FN_GPIO     2'h0
`define PFM_FN_ALT1     2'h1
`define PFM_FN_ALT2     2'h2
`define PFM_FN_ALT3     2'h3
`define PFM_DIR_OUT     1'h1
`define PFM_DIR_IN      1'h0

`endif

/* File: hdl/pfm_pkg.sv */
package pfm_pkg;
	typedef enum logic [2:0] {
		PFM_IDLE   = 3'h1,
		PFM_ACCESS = 3'h2,
		PFM_DONE   = 3'h4
	} pfm_state_t;
	typedef logic [1:0] pfm_func_t;
endpackage

/* File: hdl/pfm_pin_cell.sv */
`timescale 1ns/1ps
`include "pfm_defs.svh"

module pfm_pin_cell #(
	parameter logic [3:0] alt_is_out = 4'h0,
	parameter logic [3:0] alt_valid  = 4'h0
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clk_en,
	input  wire pfm_pkg::pfm_func_t sel,
	input  wire logic             gpio_out,
	input  wire logic             gpio_dir,
	input  wire logic [3:1]       alt_out,
	input  wire logic             pin_in,
	output logic                  pin_out,
	output logic                  pin_oe,
	output logic                  gpio_in,
	output logic [3:1]            alt_in
);
	// Reserved codes leave the pad undriven and give the peripheral a 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 1'b0;
			pin_oe  <= `PFM_DIR_IN;
			gpio_in <= 1'b0;
			alt_in  <= 3'h0;
		end else if (clk_en) begin
			gpio_in <= pin_in;
			if (sel == `PFM_FN_GPIO) begin
				pin_out <= gpio_out;
				pin_oe  <= gpio_dir; // RULE3
			end else begin
				pin_out <= alt_out[sel];
				pin_oe  <= alt_is_out[sel] & alt_valid[sel]; // RULE3
			end
			for (int i = 1; i < 4; i++) begin
				alt_in[i] <= (sel == i[1:0]) && alt_valid[i] && !alt_is_out[i] ? pin_in : 1'b0; // RULE6
			end
		end
	end
endmodule // pfm_pin_cell

/* File: hdl/pfm_mux.sv */
//
// Function
// (RULE1) Each pin connects to GPIO or one peripheral signal by register field
// (RULE2) Three read/write select registers at C000, C004, C014
// (RULE3) GPIO direction used only for GPIO; other functions set direction
// (RULE4) Software must not write reserved field encodings
// (RULE5) Software routes a peripheral before enabling it or its interrupt
// (RULE6) Unrouted enabled peripherals give undefined, not relied-on activity
// (RULE7) Bits 1:0 pin zero, bits 3:2 pin one encodings, reset zero
// (RULE8) Bits 5:4 pin two: GPIO, I2C clock, capture 0, reserved
// (RULE9) Bits 7:6 pin three: GPIO, I2C data, match 0, interrupt 1
// (RULE10) Bits 9:8 pin four: GPIO, SPI clock, capture 1, reserved
// (RULE11) Writes change routing next cycle; reads return last written value
`timescale 1ns/1ps
`include "pfm_defs.svh"

module pfm_mux (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic [4:0]  pin_in,
	output logic [4:0]       pin_out,
	output logic [4:0]       pin_oe,
	input  wire logic [4:0]  gpio_out,
	input  wire logic [4:0]  port_direction_control,
	output logic [4:0]       gpio_in,
	input  wire logic        serial_port0_transmit,
	output logic             serial_port0_receive,
	input  wire logic        pwm_output_1,
	input  wire logic        pwm_output_3,
	output logic             external_interrupt_0,
	output logic             external_interrupt_1,
	input  wire logic        i2c_scl_out_low,
	output logic             i2c_scl_in,
	input  wire logic        i2c_sda_out_low,
	output logic             i2c_sda_in,
	input  wire logic        spi0_sck_out,
	input  wire logic        spi0_sck_oe,
	output logic             spi0_sck_in,
	output logic             timer0_capture_0,
	input  wire logic        timer0_match_0,
	output logic             timer0_capture_1
);
	logic [31:0]          pin_function_select_0;
	logic [31:0]          pin_function_select_1;
	logic [31:0]          pin_function_select_2;
	pfm_pkg::pfm_state_t  state;
	logic [3:1]           alt_out [`PFM_NPINS];
	logic [3:1]           alt_in [`PFM_NPINS];
	logic [4:0]           cell_oe;

	function automatic logic [1:0] pfm_decode(input logic [31:0] addr);
		if (addr == `PFM_ADDR_SEL0) begin
			pfm_decode = 2'h1;
		end else if (addr == `PFM_ADDR_SEL1) begin
			pfm_decode = 2'h2;
		end else if (addr == `PFM_ADDR_SEL2) begin
			pfm_decode = 2'h3;
		end else begin
			pfm_decode = 2'h0;
		end
	endfunction

	// APB slave: one wait-free access phase, pready pulses in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= pfm_pkg::PFM_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (clk_en) begin
			case (state)
				// DONE takes a setup too, so a back-to-back transfer is not lost
				pfm_pkg::PFM_IDLE, pfm_pkg::PFM_DONE: begin
					pready  <= 1'b0;
					pslverr <= 1'b0;
					if (psel && !penable) begin
						state   <= pfm_pkg::PFM_ACCESS;
						pready  <= 1'b1;
						pslverr <= (pfm_decode(paddr) == 2'h0);
						if (pfm_decode(paddr) == 2'h1) begin
							prdata <= pin_function_select_0; // RULE11
						end else if (pfm_decode(paddr) == 2'h2) begin
							prdata <= pin_function_select_1;
						end else if (pfm_decode(paddr) == 2'h3) begin
							prdata <= pin_function_select_2;
						end else begin
							prdata <= 32'h00000000;
						end
					end
				end
				pfm_pkg::PFM_ACCESS: begin
					state   <= pfm_pkg::PFM_DONE;
					pready  <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					state <= pfm_pkg::PFM_IDLE;
				end
			endcase
		end
	end

	// Writes land at the access edge sampled with pready high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_function_select_0 <= `PFM_RESET_SEL; // RULE7
			pin_function_select_1 <= `PFM_RESET_SEL;
			pin_function_select_2 <= `PFM_RESET_SEL;
		end else if (clk_en && psel && penable && pready && pwrite) begin
			if (pfm_decode(paddr) == 2'h1) begin
				pin_function_select_0 <= pwdata; // RULE2
			end else if (pfm_decode(paddr) == 2'h2) begin
				pin_function_select_1 <= pwdata; // RULE2
			end else if (pfm_decode(paddr) == 2'h3) begin
				pin_function_select_2 <= pwdata; // RULE2
			end
		end
	end

	// Alternate outputs per pin, index = field code; I2C is open drain
	always_comb begin
		alt_out[0] = {1'b0, pwm_output_1, serial_port0_transmit}; // RULE7
		alt_out[1] = {1'b0, pwm_output_3, 1'b0}; // RULE7
		alt_out[2] = {1'b0, 1'b0, 1'b0}; // RULE8
		alt_out[3] = {1'b0, timer0_match_0, 1'b0}; // RULE9
		alt_out[4] = {1'b0, 1'b0, spi0_sck_out}; // RULE10
	end

	// Open-drain and clock alternates count as inputs; their enables come from the peripheral
	localparam logic [3:0] ALT_OUT_MASK [`PFM_NPINS] = '{4'h6, 4'h4, 4'h0, 4'h4, 4'h0};
	localparam logic [3:0] ALT_VLD_MASK [`PFM_NPINS] = '{4'h6, 4'hE, 4'h6, 4'hE, 4'h6};

	genvar g;
	generate
		for (g = 0; g < `PFM_NPINS; g++) begin : g_pin
			pfm_pin_cell #(
				.alt_is_out (ALT_OUT_MASK[g]),
				.alt_valid  (ALT_VLD_MASK[g])
			) u_cell (
				.pclk     (pclk),
				.presetn  (presetn),
				.clk_en   (clk_en),
				.sel      (pin_function_select_0[g*`PFM_FIELD_W +: `PFM_FIELD_W]), // RULE1
				.gpio_out (gpio_out[g]),
				.gpio_dir (port_direction_control[g]),
				.alt_out  (alt_out[g]),
				.pin_in   (pin_in[g]),
				.pin_out  (pin_out[g]),
				.pin_oe   (cell_oe[g]),
				.gpio_in  (gpio_in[g]),
				.alt_in   (alt_in[g])
			);
		end
	endgenerate

	// Bidirectional alternates (I2C open drain, SPI clock) need their own enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe <= 5'h00;
		end else if (clk_en) begin
			pin_oe <= 5'h00;
			for (int i = 0; i < `PFM_NPINS; i++) begin
				if (pin_function_select_0[i*2 +: 2] == `PFM_FN_GPIO) begin
					pin_oe[i] <= port_direction_control[i]; // RULE3
				end else if (pin_function_select_0[i*2 +: 2] == `PFM_FN_ALT1 && i == 2) begin
					pin_oe[i] <= i2c_scl_out_low; // RULE8
				end else if (pin_function_select_0[i*2 +: 2] == `PFM_FN_ALT1 && i == 3) begin
					pin_oe[i] <= i2c_sda_out_low; // RULE9
				end else if (pin_function_select_0[i*2 +: 2] == `PFM_FN_ALT1 && i == 4) begin
					pin_oe[i] <= spi0_sck_oe; // RULE10
				end else begin
					pin_oe[i] <= cell_oe[i]; // RULE3
				end
			end
		end
	end

	// Unrouted peripheral inputs see 0; their activity is not defined
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_port0_receive <= 1'b0;
			external_interrupt_0 <= 1'b0;
			external_interrupt_1 <= 1'b0;
			i2c_scl_in           <= 1'b0;
			i2c_sda_in           <= 1'b0;
			spi0_sck_in          <= 1'b0;
			timer0_capture_0     <= 1'b0;
			timer0_capture_1     <= 1'b0;
		end else if (clk_en) begin
			serial_port0_receive <= alt_in[1][1]; // RULE7
			external_interrupt_0 <= alt_in[1][3]; // RULE7
			i2c_scl_in           <= alt_in[2][1]; // RULE8
			timer0_capture_0     <= alt_in[2][2]; // RULE8
			i2c_sda_in           <= alt_in[3][1]; // RULE9
			external_interrupt_1 <= alt_in[3][3]; // RULE9
			spi0_sck_in          <= alt_in[4][1]; // RULE10
			timer0_capture_1     <= alt_in[4][2]; // RULE10
		end
	end

	property sel_write_p;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && penable && pready && pwrite && paddr == `PFM_ADDR_SEL0)
			|=> (pin_function_select_0 == $past(pwdata));
	endproperty
	sel0_write_a: assert property (sel_write_p) else $error("select 0 write lost"); // RULE11

	readback_value_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		(clk_en && psel && !penable && !pwrite && paddr == `PFM_ADDR_SEL1
			&& state != pfm_pkg::PFM_ACCESS)
			|=> (prdata == $past(pin_function_select_1)))
		else $error("select 1 readback wrong");

	gpio_direction_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		(clk_en && pin_function_select_0[1:0] == `PFM_FN_GPIO)
			|=> (pin_oe[0] == $past(port_direction_control[0])))
		else $error("gpio direction not followed");

	txd_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		(clk_en && pin_function_select_0[1:0] == `PFM_FN_ALT1) [*2]
			|=> (pin_oe[0] == `PFM_DIR_OUT))
		else $error("transmit pin not driven");

	sequence pwm_output_1_sel_s;
		clk_en && pin_function_select_0[1:0] == `PFM_FN_ALT2 ##1 clk_en;
	endsequence
	pwm_output_1_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		pwm_output_1_sel_s |-> (pin_out[0] == $past(pwm_output_1)))
		else $error("pwm 1 not routed");

	rx_unrouted_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		(clk_en && pin_function_select_0[3:2] != `PFM_FN_ALT1) [*2] |=> !serial_port0_receive)
		else $error("receive input active while unrouted");

	cap0_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		(clk_en && pin_function_select_0[5:4] == `PFM_FN_ALT2) ##1 clk_en
			|=> (timer0_capture_0 == $past(pin_in[2], 2)))
		else $error("capture 0 not routed");

	rx_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		(clk_en && pin_function_select_0[3:2] == `PFM_FN_ALT1) ##1 clk_en
			|=> (serial_port0_receive == $past(pin_in[1], 2)))
		else $error("receive input not routed");

	scl_open_drain_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		(clk_en && pin_function_select_0[5:4] == `PFM_FN_ALT1) |=> !pin_out[2])
		else $error("clock line driven high");

	scl_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		(clk_en && pin_function_select_0[5:4] == `PFM_FN_ALT1)
			|=> (pin_oe[2] == $past(i2c_scl_out_low)))
		else $error("clock line enable wrong");

	sda_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		(clk_en && pin_function_select_0[7:6] == `PFM_FN_ALT1)
			|=> (pin_oe[3] == $past(i2c_sda_out_low)))
		else $error("data line enable wrong");

	match_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		(clk_en && pin_function_select_0[7:6] == `PFM_FN_ALT2)
			|=> (pin_out[3] == $past(timer0_match_0)))
		else $error("match output not routed");

	sck_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(clk_en && pin_function_select_0[9:8] == `PFM_FN_ALT1)
			|=> (pin_oe[4] == $past(spi0_sck_oe)))
		else $error("serial clock enable wrong");

	gpio_copy_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		clk_en |=> (gpio_in == $past(pin_in)))
		else $error("gpio input not copied");

	external_interrupt_1_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		(clk_en && pin_function_select_0[7:6] == `PFM_FN_GPIO) [*2] |=> !external_interrupt_1)
		else $error("interrupt 1 unrouted but active");

	sck_dir_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(clk_en && pin_function_select_0[9:8] == `PFM_FN_ALT2) [*2] |=> !pin_oe[4])
		else $error("capture pin driven");

	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		(clk_en && psel && !penable && state != pfm_pkg::PFM_ACCESS) |=> pready)
		else $error("no ready after setup");

	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		(clk_en && pready) |=> !pready)
		else $error("ready held too long");

	slverr_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		(clk_en && psel && !penable && state != pfm_pkg::PFM_ACCESS
			&& paddr != `PFM_ADDR_SEL0 && paddr != `PFM_ADDR_SEL1 && paddr != `PFM_ADDR_SEL2)
			|=> pslverr)
		else $error("unmapped access not refused");

	sel1_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		(clk_en && psel && penable && pready && pwrite && paddr == `PFM_ADDR_SEL1)
			|=> (pin_function_select_1 == $past(pwdata)))
		else $error("select 1 write lost");

	sel2_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		(clk_en && psel && penable && pready && pwrite && paddr == `PFM_ADDR_SEL2)
			|=> (pin_function_select_2 == $past(pwdata)))
		else $error("select 2 write lost");
endmodule // pfm_mux

/* File: bench/pfm_pad_model.sv */
`timescale 1ns/1ps

module pfm_pad_model (
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	input  wire logic [4:0] ext_level,
	output logic [4:0]      pad
);
	// No pull on these pads: an undriven pad follows the outside driver
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pad[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule // pfm_pad_model

/* File: bench/tb.sv */
`timescale 1ns/1ps

module tb;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [31:0] paddr = 32'h00000000;
	logic [31:0] pwdata = 32'h00000000;
	logic        pready, pslverr;
	logic [31:0] prdata;
	logic [4:0]  pad, pin_out, pin_oe, gpio_in;
	logic [4:0]  ext_level = 5'h1F;
	logic [4:0]  dir = 5'h0A;
	logic        per_hi = 1'h1;
	logic        clk_en = 1'h1;
	logic [4:0]  gpo = 5'h02;
	logic        i2c_low = 1'h0;
	logic        rx, ei0, ei1, scl_in, sda_in, sck_in, cap0, cap1;
	logic [31:0] q;
	logic        e;
	int          n_errors = 0;
	int          check_count = 0;
	logic [31:0] sel_addr [3] = '{32'hE002C000, 32'hE002C004, 32'hE002C014};
	logic [4:0]  exp_oe [4] = '{5'h0A, 5'h11, 5'h0B, 5'h00};
	logic [4:0]  exp_out [4] = '{5'h02, 5'h11, 5'h0B, 5'h00};
	logic [7:0]  exp_in [4] = '{8'h00, 8'h9C, 8'h03, 8'h60};

	pfm_mux i_pfm_mux (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_in(pad),
		.pin_out(pin_out), .pin_oe(pin_oe), .gpio_out(gpo),
		.port_direction_control(dir), .gpio_in(gpio_in),
		.serial_port0_transmit(per_hi), .serial_port0_receive(rx),
		.pwm_output_1(per_hi), .pwm_output_3(per_hi), .external_interrupt_0(ei0),
		.external_interrupt_1(ei1), .i2c_scl_out_low(i2c_low), .i2c_scl_in(scl_in),
		.i2c_sda_out_low(i2c_low), .i2c_sda_in(sda_in), .spi0_sck_out(per_hi),
		.spi0_sck_oe(per_hi), .spi0_sck_in(sck_in), .timer0_capture_0(cap0),
		.timer0_match_0(per_hi), .timer0_capture_1(cap1));

	pfm_pad_model i_pfm_pad_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .pad(pad));

	initial begin
		forever #4 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			n_errors++;
			give_verdict();
		end
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 3; i++) begin
			apb(1'h0, sel_addr[i], 32'h0);
			check("reset value", q, 32'h00000000);
			apb(1'h1, sel_addr[i], 32'hA5A55A5A ^ i);
			apb(1'h0, sel_addr[i], 32'h0);
			check("readback", q, 32'hA5A55A5A ^ i);
			check("slverr mapped", {31'h0, e}, 32'h0);
		end
		// An alias with the same word index bits but address bit 24 set must not reach the first register
		apb(1'h1, 32'hE102C000, 32'h12345678);
		apb(1'h0, 32'hE002C008, 32'h0);
		check("slverr unmapped", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		apb(1'h0, sel_addr[0], 32'h0);
		check("alias write", q, 32'hA5A55A5A);
		// Every code on every pin; code 3 only where it names a function
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, sel_addr[0], (c == 3) ? 32'h000000CC : {22'h0, {5{c[1:0]}}});
			// Input routes lag the pad by two edges after the pad settles
			repeat (5) @(posedge pclk);
			@(negedge pclk);
			check("pin enables", {27'h0, pin_oe}, {27'h0, exp_oe[c]});
			check("pin drive", {27'h0, pin_out & pin_oe}, {27'h0, exp_out[c]});
			check("routed inputs", {24'h0, rx, ei0, ei1, scl_in, sda_in, sck_in,
				cap0, cap1}, {24'h0, exp_in[c]});
			if (c == 0) begin
				check("gpio input", {27'h0, gpio_in}, 32'h17);
			end
		end
		@(posedge pclk);
		dir <= 5'h15;
		apb(1'h1, sel_addr[0], 32'h0);
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		check("gpio direction", {27'h0, pin_oe}, 32'h15);
		// Enable low must hold the pin enables against a new direction
		@(posedge pclk);
		clk_en <= 1'h0;
		dir <= 5'h0A;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		check("frozen direction", {27'h0, pin_oe}, 32'h15);
		@(posedge pclk);
		clk_en <= 1'h1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check("released direction", {27'h0, pin_oe}, 32'h0A);
		give_verdict();
	end
endmodule // tb
